// ### common/dual_mode_serial_port_regs.vh
// Purpose: register map, field positions, reset values and timing constants of the serial port
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   narrow registers sit in the low bits, upper bits read as zero
`ifndef DUAL_MODE_SERIAL_PORT_REGS_VH
`define DUAL_MODE_SERIAL_PORT_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE     5'h00
`define OFS_CTRL0    5'h04
`define OFS_CTRL1    5'h08
`define OFS_BRG      5'h0C
`define OFS_TXBUF    5'h10
`define OFS_RXBUF    5'h14
`define OFS_IRQ      5'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_EXTCLK  3
`define MODE_STOP2   4
`define MODE_EVEN    5
`define MODE_PAREN   6
`define CTRL0_RTSSEL 2
`define CTRL0_IDLE   3
`define CTRL1_TE     0
`define CTRL1_TI     1
`define CTRL1_RE     2
`define CTRL1_RI     3
`define CTRL1_OVR    4
`define IRQ_TX       0
`define IRQ_RX       1

// ----------------------------------------
// format codes in mode bits 2..0
// ----------------------------------------
`define FMT_SYNC     3'h1
`define FMT_ASYNC7   3'h4
`define FMT_ASYNC8   3'h5
`define FMT_ASYNC9   3'h6

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_MODE     8'h00
`define RST_CTRL0    8'h08
`define RST_CTRL1    8'h02
`define RST_BRG      8'h00
`define SYNC_BITS    4'h8
`define ASYNC_OVS    4'hF
`define SRC_DIV0     1
`define SRC_DIV1     4
`define SRC_DIV2     16
`define SRC_DIV3     64

`endif

// ### rtl/dual_mode_serial_port.v
// Purpose: clock-synchronous / asynchronous serial port with Avalon-MM registers
// Assumes: all pins synchronous to clk_sys; async reception handled elsewhere
// Notes:   one wait state on every bus access; clock pin doubles as external source
`include "dual_mode_serial_port_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dual_mode_serial_port #(
   parameter DIV0 = `SRC_DIV0,
   parameter DIV1 = `SRC_DIV1,
   parameter DIV2 = `SRC_DIV2,
   parameter DIV3 = `SRC_DIV3
) (
   input  wire        clk_sys,
   input  wire        arst_n,
   input  wire [4:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   input  wire        clk_pin_in,
   output reg         clk_pin_out,
   output reg         clk_pin_oe,
   output reg         txd,
   input  wire        rxd,
   input  wire        flow_in,
   output reg         flow_out,
   output reg         flow_oe
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]  mode_q;
   reg  [2:0]  ctrl0_q;
   reg         te_q;
   reg         ti_q;
   reg         re_q;
   reg         ri_q;
   reg         ovr_q;
   reg         idle_q;
   reg  [7:0]  brg_q;
   reg  [8:0]  txbuf_q;
   reg  [7:0]  rxbuf_q;
   reg  [1:0]  irq_q;
   reg  [8:0]  pre_q;
   reg  [7:0]  brg_cnt_q;
   reg  [3:0]  ovs_q;
   reg         clk_prev_q;
   reg         busy_q;
   reg         tend_q;
   reg  [12:0] sh_q;
   reg  [3:0]  left_q;
   reg  [3:0]  rise_cnt_q;
   reg  [7:0]  rxsh_q;
   reg  [3:0]  rxcnt_q;

   wire        acc_done = (read | write) & ~waitrequest;
   wire        wr_go = write & ~waitrequest;
   wire        rd_go = read & ~waitrequest;
   wire        is_sync = (mode_q[2:0] == `FMT_SYNC);
   wire        is_async = mode_q[2] & (mode_q[1:0] != 2'h3);
   wire        ext_clk = mode_q[`MODE_EXTCLK];
   wire        pin_rise = clk_pin_in & ~clk_prev_q;
   wire        pin_fall = ~clk_pin_in & clk_prev_q;

   // ----------------------------------------
   // source clock and bit-rate divider
   // ----------------------------------------
   // prescaler terminal count for one source divide, cut to counter width;
   // a divide of 1 gives a source tick on every clock, the fastest setting
   function [8:0] lim_of;
      input integer div;
      integer full;
      begin
         full = div - 1;
         lim_of = full[8:0];
      end
   endfunction

   // source select picks the terminal count; a change mid-frame
   // stretches or cuts the bit in flight, so set it while idle
   reg  [8:0]  pre_lim;
   always @* begin
      case (ctrl0_q[1:0])
         2'h0:    pre_lim = lim_of(DIV0);
         2'h1:    pre_lim = lim_of(DIV1);
         2'h2:    pre_lim = lim_of(DIV2);
         default: pre_lim = lim_of(DIV3);
      endcase
   end

   // external source only counts in async; sync external shifts on the pin itself
   wire        int_tick = (pre_q >= pre_lim);
   wire        src_tick = ext_clk ? pin_rise : int_tick;
   wire        brg_tick = src_tick & (brg_cnt_q == 8'h00);
   wire        bit_tick = brg_tick & (ovs_q == `ASYNC_OVS);

   // ----------------------------------------
   // shift clock events in sync mode
   // ----------------------------------------
   // internal: sclk toggles on each divider tick only while a frame is out
   wire        sy_fall = is_sync & busy_q & (ext_clk ? pin_fall : (brg_tick & clk_pin_out));
   wire        sy_rise_int = is_sync & ~ext_clk & busy_q & brg_tick & ~clk_pin_out;
   wire        sy_rise = is_sync & (ext_clk ? pin_rise : sy_rise_int);

   // ----------------------------------------
   // transmit start and async frame build
   // ----------------------------------------
   wire        permit = ctrl0_q[`CTRL0_RTSSEL] | ~flow_in;
   wire        start = tend_q & te_q & ~ti_q & permit & (is_sync | is_async);

   reg  [12:0] frame;
   reg  [3:0]  frame_len;
   reg  [3:0]  dlen;
   reg  [8:0]  dmask;
   reg         par;
   integer     i;
   always @* begin
      frame = 13'h1FFF;
      dlen = (mode_q[1:0] == 2'h0) ? 4'h7 : (mode_q[1:0] == 2'h1) ? 4'h8 : 4'h9;
      dmask = txbuf_q & ((9'h001 << dlen) - 9'h001);
      par = (^dmask) ^ ~mode_q[`MODE_EVEN];
      frame[0] = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
         if (i < dlen) begin
            frame[1 + i] = dmask[i];
         end
      end
      if (mode_q[`MODE_PAREN]) begin
         frame[1 + dlen] = par;
      end
      frame_len = 4'h1 + dlen + {3'h0, mode_q[`MODE_PAREN]} + (mode_q[`MODE_STOP2] ? 4'h2 : 4'h1);
   end

   // ----------------------------------------
   // prescaler, divider and oversample counters
   // ----------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= 9'h000;
         brg_cnt_q <= 8'h00;
         ovs_q <= 4'h0;
         clk_prev_q <= 1'b1;
      end else begin
         clk_prev_q <= clk_pin_in;
         pre_q <= int_tick ? 9'h000 : pre_q + 9'h001;
         if (src_tick) begin
            brg_cnt_q <= (brg_cnt_q == 8'h00) ? brg_q : brg_cnt_q - 8'h01;
         end
         if (start) begin
            ovs_q <= 4'h0;                                          // bit phase starts with frame
         end else if (brg_tick) begin
            ovs_q <= ovs_q + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         tend_q <= 1'b1;
         idle_q <= 1'b1;
         sh_q <= 13'h1FFF;
         left_q <= 4'h0;
         rise_cnt_q <= 4'h0;
         txd <= 1'b1;
         clk_pin_out <= 1'b1;
      end else begin
         tend_q <= ~busy_q & ~start;
         if (start) begin
            idle_q <= 1'b0;
         end else if (tend_q) begin
            idle_q <= 1'b1;
         end
         if (start) begin
            busy_q <= 1'b1;
            rise_cnt_q <= 4'h0;
            left_q <= frame_len;
            if (is_sync) begin
               sh_q <= {5'h1F, txbuf_q[7:0]};
            end else begin
               sh_q <= frame >> 1;
               txd <= frame[0];
            end
         end else if (busy_q & is_sync) begin
            if (~ext_clk & brg_tick) begin
               clk_pin_out <= ~clk_pin_out;
            end
            if (sy_fall) begin
               txd <= sh_q[0];
               sh_q <= {1'b1, sh_q[12:1]};
            end
            if (sy_rise) begin
               rise_cnt_q <= rise_cnt_q + 4'h1;
               if (rise_cnt_q == `SYNC_BITS - 4'h1) begin
                  busy_q <= 1'b0;
               end
            end
         end else if (busy_q & bit_tick) begin
            if (left_q == 4'h1) begin
               busy_q <= 1'b0;
               txd <= 1'b1;
            end else begin
               txd <= sh_q[0];
               sh_q <= {1'b1, sh_q[12:1]};
               left_q <= left_q - 4'h1;
            end
         end else if (~busy_q) begin
            clk_pin_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // sync receiver and receive-ready output
   // ----------------------------------------
   wire        rx_word = sy_rise & re_q & (rxcnt_q == `SYNC_BITS - 4'h1);
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rxsh_q <= 8'h00;
         rxcnt_q <= 4'h0;
         rxbuf_q <= 8'h00;
         flow_out <= 1'b1;
      end else begin
         if (!re_q) begin
            rxcnt_q <= 4'h0;
            flow_out <= 1'b1;
         end else if (sy_rise) begin
            rxsh_q <= {rxd, rxsh_q[7:1]};
            rxcnt_q <= rx_word ? 4'h0 : rxcnt_q + 4'h1;
            flow_out <= ~rx_word;
            if (rx_word) begin
               rxbuf_q <= {rxd, rxsh_q[7:1]};
            end
         end else if (rxcnt_q == 4'h0) begin
            flow_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // pin enables
   // ----------------------------------------
   // async with internal clock leaves the clock pin to general I/O
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clk_pin_oe <= 1'b0;
         flow_oe <= 1'b0;
      end else begin
         clk_pin_oe <= is_sync & ~ext_clk;
         flow_oe <= ctrl0_q[`CTRL0_RTSSEL];
      end
   end

   // ----------------------------------------
   // registers and status flags
   // ----------------------------------------
   wire        wr_txbuf = wr_go & (address == `OFS_TXBUF);
   wire        rd_rxbuf = rd_go & (address == `OFS_RXBUF);
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= `RST_MODE;
         ctrl0_q <= 3'h0;
         te_q <= 1'b0;
         re_q <= 1'b0;
         brg_q <= `RST_BRG;
         txbuf_q <= 9'h000;
         ti_q <= 1'b1;
         ri_q <= 1'b0;
         ovr_q <= 1'b0;
         irq_q <= 2'h0;
      end else begin
         if (wr_go & (address == `OFS_MODE)) mode_q <= writedata[7:0];
         if (wr_go & (address == `OFS_CTRL0)) ctrl0_q <= writedata[2:0];
         if (wr_go & (address == `OFS_CTRL1)) begin
            te_q <= writedata[`CTRL1_TE];
            re_q <= writedata[`CTRL1_RE];
         end
         if (wr_go & (address == `OFS_BRG)) brg_q <= writedata[7:0];
         if (wr_txbuf) txbuf_q <= writedata[8:0];
         // a write after the load leaves the new word pending
         if (wr_txbuf) begin
            ti_q <= 1'b0;
         end else if (start) begin
            ti_q <= 1'b1;
         end
         // a word landing in the read cycle keeps its flags
         if (rx_word) begin
            ri_q <= 1'b1;
            ovr_q <= ovr_q | ri_q;
         end else if (rd_rxbuf) begin
            ri_q <= 1'b0;
            ovr_q <= 1'b0;
         end else if (!re_q) begin
            ovr_q <= 1'b0;
         end
         // request bits: hardware set wins over a write-one clear
         irq_q[`IRQ_TX] <= (start & ~wr_txbuf) |
            (irq_q[`IRQ_TX] & ~(wr_go & (address == `OFS_IRQ) & writedata[`IRQ_TX]));
         irq_q[`IRQ_RX] <= (rx_word & ~ri_q) |
            (irq_q[`IRQ_RX] & ~(wr_go & (address == `OFS_IRQ) & writedata[`IRQ_RX]));
      end
   end

   // ----------------------------------------
   // Avalon-MM slave: one wait state, read data registered
   // ----------------------------------------
   // the wait state lets read data come from a flop, so no register
   // path reaches readdata combinationally; the price is one extra
   // cycle on every access, writes included
   // side effects of a read (rx buffer) land on the acknowledge edge
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (read & waitrequest) begin
            case (address)
               `OFS_MODE:  readdata <= {24'h000000, mode_q};
               `OFS_CTRL0: readdata <= {28'h0000000, idle_q, ctrl0_q};
               // error bits 7..5 read zero and act on nothing
               `OFS_CTRL1: readdata <= {27'h0000000, ovr_q, ri_q, re_q, ti_q, te_q};
               `OFS_BRG:   readdata <= {24'h000000, brg_q};
               `OFS_TXBUF: readdata <= {23'h000000, txbuf_q};
               `OFS_RXBUF: readdata <= {24'h000000, rxbuf_q};
               `OFS_IRQ:   readdata <= {30'h00000000, irq_q};
               default:    readdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ### dv/dual_mode_serial_port_checker.sv
// Purpose: bus and link timing checks on the serial port pins
// Assumes: sync tests run divider n=2 from the fastest source
// Notes:   half periods of the shift clock are 3 cycles
`timescale 1ns/1ps
`default_nettype none
`include "dual_mode_serial_port_regs.vh"
module dual_mode_serial_port_checker #(
   parameter DIV0 = 1,
   parameter DIV1 = 4,
   parameter DIV2 = 16,
   parameter DIV3 = 64
) (
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        clk_pin_out,
   input wire logic        clk_pin_oe,
   input wire logic        txd,
   input wire logic        flow_out,
   input wire logic        flow_oe
);
   logic rx_on_q;
   wire  wr_ctrl1 = write && !waitrequest && (address == `OFS_CTRL1);
   // -------------------------
   // helper and properties
   // -------------------------
   // shadow of rx_on, so only its rising write is checked
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         rx_on_q <= 1'b0;
      else if (wr_ctrl1)
         rx_on_q <= writedata[`CTRL1_RE];
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence s_ack; !waitrequest ##1 waitrequest; endsequence
   sequence s_low; !clk_pin_out [*3] ##1 clk_pin_out; endsequence
   sequence s_high; clk_pin_out [*3]; endsequence
   property p_bus_answer; (read || write) && waitrequest |=> s_ack; endproperty
   property p_answer_cause; $fell(waitrequest) |-> $past(read || write); endproperty
   property p_clk_low; clk_pin_oe && $fell(clk_pin_out) |-> s_low; endproperty
   property p_clk_high; clk_pin_oe && $rose(clk_pin_out) |-> s_high; endproperty
   property p_shift_on_fall;
      clk_pin_oe && $past(clk_pin_oe) && $changed(txd) |-> $fell(clk_pin_out);
   endproperty
   property p_flow_select;
      write && !waitrequest && address == `OFS_CTRL0 |-> ##2 flow_oe == $past(writedata[`CTRL0_RTSSEL], 2);
   endproperty
   property p_rx_off_flow; wr_ctrl1 && !writedata[`CTRL1_RE] |-> ##2 flow_out; endproperty
   property p_rx_on_flow; wr_ctrl1 && writedata[`CTRL1_RE] && !rx_on_q |-> ##2 !flow_out; endproperty
   property p_unused_bits;
      read && !waitrequest && address == `OFS_CTRL1 |-> readdata[7:5] == 3'h0;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
   a_answer_cause: assert property (p_answer_cause) else $error("answer without request");
   a_clk_low: assert property (p_clk_low) else $error("shift clock low phase wrong");
   a_clk_high: assert property (p_clk_high) else $error("shift clock high phase wrong");
   a_shift_on_fall: assert property (p_shift_on_fall) else $error("txd moved off falling clock");
   a_flow_select: assert property (p_flow_select) else $error("flow pin direction wrong");
   a_rx_off_flow: assert property (p_rx_off_flow) else $error("flow out low while rx off");
   a_rx_on_flow: assert property (p_rx_on_flow) else $error("flow out not ready");
   a_unused_bits: assert property (p_unused_bits) else $error("error bits not zero");
endmodule
bind dual_mode_serial_port dual_mode_serial_port_checker #(.DIV0(DIV0), .DIV1(DIV1), .DIV2(DIV2), .DIV3(DIV3))
   i_dual_mode_serial_port_checker (.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .txd(txd), .flow_out(flow_out), .flow_oe(flow_oe));
`default_nettype wire

// ### dv/sync_far_port.sv
// Purpose: far sync port taking its shift clock from the block
// Assumes: block drives the clock pin (internal sync mode)
// Notes:   between frames the data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sync_far_port (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       sclk,
   input  wire logic       sclk_oe,
   input  wire logic       sdi,
   input  wire logic [7:0] reply,
   output logic            sdo,
   output logic [7:0]      heard,
   output logic [7:0]      words
);
   logic       sclk_q;
   logic [3:0] nbits;
   logic [7:0] shreg;
   // edges found on clk_sys, so no second clock domain in the model
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclk_q <= 1'b1;
         nbits  <= 4'h0;
         shreg  <= 8'h00;
         heard  <= 8'h00;
         words  <= 8'h00;
         sdo    <= 1'b1;
      end else begin
         sclk_q <= sclk;
         if (sclk_oe && sclk && !sclk_q) begin
            // lsb arrives first
            shreg <= {sdi, shreg[7:1]};
            nbits <= (nbits == 4'h7) ? 4'h0 : nbits + 4'h1;
            if (nbits == 4'h7) begin
               heard <= {sdi, shreg[7:1]};
               words <= words + 8'h01;
               sdo   <= ~sdo; // inverse of last bit, no stale bit
            end
         end else if (sclk_oe && !sclk && sclk_q) begin
            sdo <= reply[nbits[2:0]]; // next bit after falling clock
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/test_dual_mode_serial_port.sv
// Purpose: register-level tests of the serial port
// Assumes: fastest source, divider n=2 in sync, n=0 in async
// Notes:   async first bit may be short, so bits are timed from start end
`timescale 1ns/1ps
`default_nettype none
`include "dual_mode_serial_port_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_dual_mode_serial_port;
   logic        clk_sys;
   logic        arst_n;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        clk_pin_in;
   logic        clk_pin_out;
   logic        clk_pin_oe;
   logic        txd;
   logic        rxd;
   logic        flow_in;
   logic        flow_out;
   logic        flow_oe;
   logic [7:0]  heard;
   logic [7:0]  words;
   logic [7:0]  modes [3];
   logic [31:0] rd;
   logic [11:0] got;
   logic [11:0] exp;
   logic [8:0]  dat;
   int          checks;
   int          mismatches;
   int          i;
   int          m;
   int          nb;
   dual_mode_serial_port i_dual_mode_serial_port (.clk_sys(clk_sys), .arst_n(arst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe), .txd(txd), .rxd(rxd),
      .flow_in(flow_in), .flow_out(flow_out), .flow_oe(flow_oe));
   sync_far_port i_sync_far_port (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(clk_pin_out), .sclk_oe(clk_pin_oe),
      .sdi(txd), .reply(8'h5A), .sdo(rxd), .heard(heard), .words(words));
   // -------------------------
   // clock, bus tasks, verdict
   // -------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // request held until waitrequest is seen low, then one idle cycle
   task automatic bus_acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= !wr;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
      bus_acc(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // polls a status bit, bounded
   task automatic wait_bit(input logic [4:0] a, input int b);
      rd = 32'h0;
      for (i = 0; i < 100 && rd[b] !== 1'b1; i++) bus_acc(1'b0, a, 32'h0);
   endtask
   task automatic wait_words(input logic [7:0] n);
      for (i = 0; i < 3000 && words !== n; i++) @(posedge clk_sys);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      results();
   end
   // -------------------------
   // main sequence
   // -------------------------
   initial begin
      {arst_n, read, write, address, writedata} = '0;
      {flow_in, clk_pin_in} = 2'b11;
      {checks, mismatches} = '0;
      modes = '{8'h54, 8'h65, 8'h16}; // odd+2 stops, even+1 stop, no parity+2 stops
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      `CHK({waitrequest, txd, clk_pin_out, clk_pin_oe, flow_out, flow_oe}, 6'b111010)
      chk_rd(`OFS_MODE, 32'h00);
      chk_rd(`OFS_CTRL0, 32'h08);
      chk_rd(`OFS_CTRL1, 32'h02);
      chk_rd(`OFS_BRG, 32'h00);
      chk_rd(`OFS_IRQ, 32'h00);
      chk_rd(5'h1C, 32'h00);
      // receive-ready pin selected while flow_in stays high
      bus_acc(1'b1, `OFS_CTRL0, 32'h04);
      bus_acc(1'b1, `OFS_BRG, 32'h02);
      bus_acc(1'b1, `OFS_MODE, 32'h01);
      @(posedge clk_sys);
      `CHK({clk_pin_oe, flow_oe, flow_out}, 3'b111)
      bus_acc(1'b1, `OFS_CTRL1, 32'h05);
      @(posedge clk_sys);
      `CHK(flow_out, 1'b0)
      bus_acc(1'b1, `OFS_TXBUF, 32'hA5); // dummy words also clock the receiver
      wait_bit(`OFS_CTRL1, 1);
      `CHK(rd[1], 1'b1)
      chk_rd(`OFS_CTRL0, 32'h04);
      chk_rd(`OFS_IRQ, 32'h01);
      bus_acc(1'b1, `OFS_TXBUF, 32'h3C); // queued before the frame ends
      wait_words(8'h01);
      `CHK(heard, 8'hA5)
      wait_words(8'h02);
      `CHK(heard, 8'h3C)
      wait_bit(`OFS_CTRL0, 3);
      `CHK(rd, 32'h0C)
      chk_rd(`OFS_CTRL1, 32'h1F);
      chk_rd(`OFS_IRQ, 32'h03);
      bus_acc(1'b1, `OFS_IRQ, 32'h03);
      chk_rd(`OFS_IRQ, 32'h00);
      bus_acc(1'b1, `OFS_CTRL1, 32'h01);
      chk_rd(`OFS_CTRL1, 32'h0B);
      `CHK(flow_out, 1'b1)
      chk_rd(`OFS_RXBUF, 32'h5A);
      chk_rd(`OFS_CTRL1, 32'h03);
      // enable dropped mid-frame
      bus_acc(1'b1, `OFS_TXBUF, 32'h81);
      wait_bit(`OFS_CTRL1, 1);
      bus_acc(1'b1, `OFS_CTRL1, 32'h00);
      wait_words(8'h03);
      `CHK(heard, 8'h81)
      // send-permit input holds the start off until low
      bus_acc(1'b1, `OFS_CTRL0, 32'h00);
      bus_acc(1'b1, `OFS_CTRL1, 32'h01);
      bus_acc(1'b1, `OFS_TXBUF, 32'h42);
      repeat (60) @(posedge clk_sys);
      chk_rd(`OFS_CTRL1, 32'h01);
      flow_in <= 1'b0;
      wait_words(8'h04);
      `CHK(heard, 8'h42)
      // external shift clock from the bench: txd moves on its fall
      bus_acc(1'b1, `OFS_MODE, 32'h09);
      bus_acc(1'b1, `OFS_TXBUF, 32'h96);
      repeat (4) @(posedge clk_sys);
      for (i = 0; i < 8; i++) begin
         clk_pin_in <= 1'b0;
         repeat (4) @(posedge clk_sys);
         got[i] = txd;
         clk_pin_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
      end
      `CHK(got[7:0], 8'h96)
      // async 7, 8 and 9 bit frames, bits timed from end of start
      bus_acc(1'b1, `OFS_BRG, 32'h00);
      for (m = 0; m < 3; m++) begin
         bus_acc(1'b1, `OFS_MODE, {24'h0, modes[m]});
         dat = 9'h1B1 & ((9'h001 << (7 + m)) - 9'h001);
         exp = {3'b000, dat};
         nb = 7 + m;
         if (modes[m][`MODE_PAREN]) begin
            exp[nb] = modes[m][`MODE_EVEN] ? ^dat : ~^dat;
            nb++;
         end
         exp[nb] = 1'b1;
         nb = nb + (modes[m][`MODE_STOP2] ? 2 : 1);
         if (modes[m][`MODE_STOP2])
            exp[nb - 1] = 1'b1;
         got = 12'h000;
         bus_acc(1'b1, `OFS_TXBUF, 32'h1B1);
         for (i = 0; i < 400 && txd !== 1'b0; i++) @(posedge clk_sys);
         for (i = 0; i < 400 && txd !== 1'b1; i++) @(posedge clk_sys);
         repeat (8) @(posedge clk_sys);
         for (i = 0; i < nb; i++) begin
            got[i] = txd;
            repeat (16) @(posedge clk_sys);
         end
         `CHK(got, exp)
         `CHK({clk_pin_oe, txd}, 2'b01)
      end
      results();
   end
endmodule
`default_nettype wire
